// File: hdl/hdlcam_regs.sv
// Operation
// - TEI pattern bits 7-1, extension bit 0
// - SAPI pattern 7-2, C/R 1, extension 0
// - Widening register, two bits per identifier
// - Mode 00: exact SAPI only
// - Mode 01: exact SAPI or zero
// - Mode 10: exact SAPI or 63
// - Mode 11: any SAPI matches
// - TEI mode: undefined, exact, +127, any
// - C/R compared only when enabled
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/10ps
module hdlcam_regs (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Write address channel
  input wire logic [hdlcam_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  // Write data channel
  input wire logic [hdlcam_pkg::DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // Write response channel
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // Read address channel
  input wire logic [hdlcam_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  // Read data channel
  output logic [hdlcam_pkg::DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Receiver octet stream
  input wire logic rx_frame_start,
  input wire logic rx_octet_valid,
  input wire logic [7:0] rx_octet,
  // Recognition result
  output logic addr_checked,
  output logic addr_match,
  output logic [hdlcam_pkg::N_DLCI-1:0] addr_hit_dlci
);
  import hdlcam_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Register storage
  logic [7:0] sapi_pat [N_DLCI];
  logic [7:0] tei_pat [N_DLCI];
  logic [CRE_W-1:0] cr_enable;
  logic [7:0] sapi_widen;
  logic [7:0] tei_widen;
  logic last_match;

  // Write channel holding state
  logic aw_full;
  logic w_full;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [7:0] w_data_q;
  logic w_lane0_q;
  logic next_aw_full;
  logic next_w_full;
  logic next_bvalid;
  logic next_rvalid;

  ////////////////////////////////////////////////////////////////////////////
  // Write and read handshake decode
  wire aw_take = awvalid && awready;
  wire w_take = wvalid && wready;
  wire do_write = aw_full && w_full && !bvalid;
  wire wr_en = do_write && w_lane0_q;
  wire b_done = bvalid && bready;
  wire ar_take = arvalid && arready;
  wire r_done = rvalid && rready;

  // Next state of the write channel flags and of rvalid
  assign next_aw_full = aw_take ? 1'b1 : (do_write ? 1'b0 : aw_full);
  assign next_w_full = w_take ? 1'b1 : (do_write ? 1'b0 : w_full);
  assign next_bvalid = do_write ? 1'b1 : (b_done ? 1'b0 : bvalid);
  assign next_rvalid = ar_take ? 1'b1 : (r_done ? 1'b0 : rvalid);

  // Register selects for the pending write
  logic [N_DLCI-1:0] sel_sapi;
  logic [N_DLCI-1:0] sel_tei;
  genvar gi;
  for (gi = 0; gi < N_DLCI; gi++) begin : g_sel
    assign sel_sapi[gi] = (aw_addr_q == reg_addr(IDX_SAPI_PAT0 +
      IDX_W'(gi * IDX_PAIR_STEP)));
    assign sel_tei[gi] = (aw_addr_q == reg_addr(IDX_TEI_PAT0 +
      IDX_W'(gi * IDX_PAIR_STEP)));
  end
  wire sel_cre = (aw_addr_q == reg_addr(IDX_CR_ENABLE));
  wire sel_swid = (aw_addr_q == reg_addr(IDX_SAPI_WIDEN));
  wire sel_twid = (aw_addr_q == reg_addr(IDX_TEI_WIDEN));
  wire sel_stat = (aw_addr_q == reg_addr(IDX_STATUS));
  wire wr_mapped = (|sel_sapi) || (|sel_tei) || sel_cre || sel_swid ||
    sel_twid || sel_stat;

  ////////////////////////////////////////////////////////////////////////////
  // Write channels: address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      awready <= 1'b0;
      wready <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= REG_RESET;
      w_lane0_q <= 1'b0;
    end else begin
      aw_full <= next_aw_full;
      w_full <= next_w_full;
      awready <= !next_aw_full && !next_bvalid;
      wready <= !next_w_full && !next_bvalid;
      if (aw_take) aw_addr_q <= awaddr;
      if (w_take) begin
        w_data_q <= wdata[7:0];
        w_lane0_q <= wstrb[0];
      end
    end
  end

  // Write response, error for an unmapped address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else begin
      bvalid <= next_bvalid;
      if (do_write) bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pattern registers, one pair per identifier
  for (gi = 0; gi < N_DLCI; gi++) begin : g_pat
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        sapi_pat[gi] <= REG_RESET;
        tei_pat[gi] <= REG_RESET;
      end else begin
        if (wr_en && sel_sapi[gi]) sapi_pat[gi] <= w_data_q;
        if (wr_en && sel_tei[gi]) tei_pat[gi] <= w_data_q;
      end
    end
  end

  // Widening and compare enable registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sapi_widen <= REG_RESET;
      tei_widen <= REG_RESET;
      cr_enable <= '0;
    end else begin
      if (wr_en && sel_swid) sapi_widen <= w_data_q;
      if (wr_en && sel_twid) tei_widen <= w_data_q;
      if (wr_en && sel_cre) cr_enable <= w_data_q[CRE_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data selection
  logic [7:0] rd_byte;
  logic rd_mapped;
  always_comb begin
    rd_byte = REG_RESET;
    rd_mapped = 1'b1;
    case (araddr)
      reg_addr(IDX_CR_ENABLE): rd_byte = {4'h0, cr_enable};
      reg_addr(IDX_SAPI_PAT0): rd_byte = sapi_pat[0];
      reg_addr(IDX_TEI_PAT0): rd_byte = tei_pat[0];
      reg_addr(IDX_SAPI_PAT1): rd_byte = sapi_pat[1];
      reg_addr(IDX_TEI_PAT1): rd_byte = tei_pat[1];
      reg_addr(IDX_SAPI_PAT2): rd_byte = sapi_pat[2];
      reg_addr(IDX_TEI_PAT2): rd_byte = tei_pat[2];
      reg_addr(IDX_SAPI_PAT3): rd_byte = sapi_pat[3];
      reg_addr(IDX_TEI_PAT3): rd_byte = tei_pat[3];
      reg_addr(IDX_SAPI_WIDEN): rd_byte = sapi_widen;
      reg_addr(IDX_TEI_WIDEN): rd_byte = tei_widen;
      reg_addr(IDX_STATUS): rd_byte = {3'h0, last_match, addr_hit_dlci};
      default: rd_mapped = 1'b0;
    endcase
  end

  // Read channel, one read at a time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end else begin
      arready <= !next_rvalid;
      rvalid <= next_rvalid;
      if (ar_take) begin
        rdata <= {24'h0, rd_byte};
        rresp <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address octet capture
  logic [7:0] sapi_octet;
  logic [7:0] tei_octet;
  logic addr_ready;
  hdlcam_addr_capture u_capture (
    .aclk(aclk),
    .aresetn(aresetn),
    .rx_frame_start(rx_frame_start),
    .rx_octet_valid(rx_octet_valid),
    .rx_octet(rx_octet),
    .sapi_octet(sapi_octet),
    .tei_octet(tei_octet),
    .addr_ready(addr_ready)
  );

  // One comparator per connection identifier
  logic [N_DLCI-1:0] sapi_ok;
  logic [N_DLCI-1:0] tei_ok;
  logic [N_DLCI-1:0] hit;
  for (gi = 0; gi < N_DLCI; gi++) begin : g_cmp
    hdlcam_dlci_cmp u_cmp (
      .sapi_octet(sapi_octet),
      .tei_octet(tei_octet),
      .sapi_pat(sapi_pat[gi]),
      .tei_pat(tei_pat[gi]),
      .sapi_mode(sapi_widen[MODE_W*gi +: MODE_W]),
      .tei_mode(tei_widen[MODE_W*gi +: MODE_W]),
      .cr_enable(cr_enable[gi]),
      .sapi_ok(sapi_ok[gi]),
      .tei_ok(tei_ok[gi]),
      .hit(hit[gi])
    );
  end

  // Result of each captured address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      addr_checked <= 1'b0;
      addr_match <= 1'b0;
      addr_hit_dlci <= '0;
      last_match <= 1'b0;
    end else begin
      addr_checked <= addr_ready;
      addr_match <= addr_ready && (|hit);
      if (addr_ready) begin
        addr_hit_dlci <= hit;
        last_match <= |hit;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  wire [1:0] smode2 = sapi_widen[5:4];
  wire [5:0] rx_sapi = sapi_octet[SAPI_HI:SAPI_LO];

  tei_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_en && sel_tei[1] |=> tei_pat[1] == $past(w_data_q))
    else $error("tei pattern write lost");
  sapi_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_en && sel_sapi[2] |=> sapi_pat[2] == $past(w_data_q))
    else $error("sapi pattern write lost");
  widen_reset_a: assert property (@(posedge aclk)
    !aresetn |=> sapi_widen == REG_RESET)
    else $error("widening register not cleared by reset");
  exact_sapi_a: assert property (@(posedge aclk) disable iff (!aresetn)
    smode2 == SMODE_EXACT && sapi_ok[2] |->
      rx_sapi == sapi_pat[2][SAPI_HI:SAPI_LO])
    else $error("exact mode accepted another sapi");
  zero_sapi_a: assert property (@(posedge aclk) disable iff (!aresetn)
    smode2 == SMODE_OR_ZERO && rx_sapi == SAPI_ZERO && !cr_enable[2]
      |-> sapi_ok[2])
    else $error("sapi zero refused in mode 01");
  all_sapi_a: assert property (@(posedge aclk) disable iff (!aresetn)
    smode2 == SMODE_OR_ALL && rx_sapi == SAPI_ALL_ONES && !cr_enable[2]
      |-> sapi_ok[2])
    else $error("sapi 63 refused in mode 10");
  any_sapi_a: assert property (@(posedge aclk) disable iff (!aresetn)
    smode2 == SMODE_ANY |-> sapi_ok[2])
    else $error("any mode refused a sapi");
  tei_undef_a: assert property (@(posedge aclk) disable iff (!aresetn)
    tei_widen[5:4] == TMODE_UNDEF |-> !hit[2] && !tei_ok[2])
    else $error("undefined identifier hit");
  cr_ignore_a: assert property (@(posedge aclk) disable iff (!aresetn)
    cr_enable[2] && smode2 != SMODE_ANY && sapi_ok[2] |->
      sapi_octet[CR_BIT] == sapi_pat[2][CR_BIT])
    else $error("c/r mismatch accepted while enabled");
  match_out_a: assert property (@(posedge aclk) disable iff (!aresetn)
    addr_ready |=> addr_match == $past(|hit) && addr_checked)
    else $error("match result wrong");
  bvalid_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");

  match_seen_c: cover property (@(posedge aclk) disable iff (!aresetn)
    addr_match);
  miss_seen_c: cover property (@(posedge aclk) disable iff (!aresetn)
    addr_checked && !addr_match);
  bcast_seen_c: cover property (@(posedge aclk) disable iff (!aresetn)
    addr_ready && hit[2] && tei_widen[5:4] == TMODE_OR_BCAST);
  bad_write_c: cover property (@(posedge aclk) disable iff (!aresetn)
    bvalid && bresp == RESP_SLVERR);

endmodule // hdlcam_regs

// File: hdl/hdlcam_pkg.sv
package hdlcam_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int IDX_W = 6;
  localparam int N_DLCI = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Register indices; the byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_CR_ENABLE = 6'h21;
  localparam logic [IDX_W-1:0] IDX_SAPI_PAT0 = 6'h22;
  localparam logic [IDX_W-1:0] IDX_TEI_PAT0 = 6'h23;
  localparam logic [IDX_W-1:0] IDX_SAPI_PAT1 = 6'h24;
  localparam logic [IDX_W-1:0] IDX_TEI_PAT1 = 6'h25;
  localparam logic [IDX_W-1:0] IDX_SAPI_PAT2 = 6'h26;
  localparam logic [IDX_W-1:0] IDX_TEI_PAT2 = 6'h27;
  localparam logic [IDX_W-1:0] IDX_SAPI_PAT3 = 6'h28;
  localparam logic [IDX_W-1:0] IDX_TEI_PAT3 = 6'h29;
  localparam logic [IDX_W-1:0] IDX_SAPI_WIDEN = 6'h2A;
  localparam logic [IDX_W-1:0] IDX_TEI_WIDEN = 6'h2B;
  localparam logic [IDX_W-1:0] IDX_STATUS = 6'h30;
  localparam logic [IDX_W-1:0] IDX_PAIR_STEP = 6'h02;

  ////////////////////////////////////////////////////////////////////////////
  // Field layout of the address octets and pattern registers
  localparam int SAPI_HI = 7;
  localparam int SAPI_LO = 2;
  localparam int CR_BIT = 1;
  localparam int EA_BIT = 0;
  localparam int TEI_HI = 7;
  localparam int TEI_LO = 1;
  localparam int MODE_W = 2;
  localparam int CRE_W = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and special address values
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [5:0] SAPI_ZERO = 6'h00;
  localparam logic [5:0] SAPI_ALL_ONES = 6'h3F;
  localparam logic [6:0] TEI_BROADCAST = 7'h7F;

  ////////////////////////////////////////////////////////////////////////////
  // Widening modes
  localparam logic [1:0] SMODE_EXACT = 2'h0;
  localparam logic [1:0] SMODE_OR_ZERO = 2'h1;
  localparam logic [1:0] SMODE_OR_ALL = 2'h2;
  localparam logic [1:0] SMODE_ANY = 2'h3;
  localparam logic [1:0] TMODE_UNDEF = 2'h0;
  localparam logic [1:0] TMODE_EXACT = 2'h1;
  localparam logic [1:0] TMODE_OR_BCAST = 2'h2;
  localparam logic [1:0] TMODE_ANY = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Address capture states
  typedef enum logic [1:0] {
    CAP_IDLE,
    CAP_WAIT_SAPI,
    CAP_WAIT_TEI
  } hdlcam_cap_state_type;

  // Byte address of a register index
  function automatic logic [ADDR_W-1:0] reg_addr(
    input logic [IDX_W-1:0] idx
  );
    return {idx, 2'h0};
  endfunction

endpackage

// File: hdl/hdlcam_addr_capture.sv
`timescale 1ns/10ps
module hdlcam_addr_capture (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Receiver octet stream
  input wire logic rx_frame_start,
  input wire logic rx_octet_valid,
  input wire logic [7:0] rx_octet,
  // Captured address
  output logic [7:0] sapi_octet,
  output logic [7:0] tei_octet,
  output logic addr_ready
);
  import hdlcam_pkg::*;

  hdlcam_cap_state_type state;
  hdlcam_cap_state_type next_state;
  wire take_sapi = rx_octet_valid && (state == CAP_WAIT_SAPI);
  wire take_tei = rx_octet_valid && (state == CAP_WAIT_TEI);

  // Walk through the two address octets of each frame
  always_comb begin
    next_state = state;
    case (state)
      CAP_IDLE: next_state = state;
      CAP_WAIT_SAPI: if (rx_octet_valid) next_state = CAP_WAIT_TEI;
      CAP_WAIT_TEI: if (rx_octet_valid) next_state = CAP_IDLE;
      default: next_state = CAP_IDLE;
    endcase
    if (rx_frame_start) next_state = CAP_WAIT_SAPI; // Restart wins
  end

  // Hold the octets until the next frame
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= CAP_IDLE;
      sapi_octet <= REG_RESET;
      tei_octet <= REG_RESET;
      addr_ready <= 1'b0;
    end else begin
      state <= next_state;
      if (take_sapi) sapi_octet <= rx_octet;
      if (take_tei) tei_octet <= rx_octet;
      addr_ready <= take_tei && !rx_frame_start;
    end
  end

endmodule // hdlcam_addr_capture

// File: hdl/hdlcam_dlci_cmp.sv
`timescale 1ns/10ps
module hdlcam_dlci_cmp (
  // Received address
  input wire logic [7:0] sapi_octet,
  input wire logic [7:0] tei_octet,
  // Settings of one connection identifier
  input wire logic [7:0] sapi_pat,
  input wire logic [7:0] tei_pat,
  input wire logic [1:0] sapi_mode,
  input wire logic [1:0] tei_mode,
  input wire logic cr_enable,
  // Results
  output logic sapi_ok,
  output logic tei_ok,
  output logic hit
);
  import hdlcam_pkg::*;

  // Field slices
  wire [5:0] rx_sapi = sapi_octet[SAPI_HI:SAPI_LO];
  wire [6:0] rx_tei = tei_octet[TEI_HI:TEI_LO];
  wire cr_same = !cr_enable ||
    (sapi_octet[CR_BIT] == sapi_pat[CR_BIT]);
  wire sapi_eq = (rx_sapi == sapi_pat[SAPI_HI:SAPI_LO]) &&
    (sapi_octet[EA_BIT] == sapi_pat[EA_BIT]);
  wire tei_eq = (rx_tei == tei_pat[TEI_HI:TEI_LO]) &&
    (tei_octet[EA_BIT] == tei_pat[EA_BIT]);
  wire sapi_zero = (rx_sapi == SAPI_ZERO);
  wire sapi_all = (rx_sapi == SAPI_ALL_ONES);
  wire tei_bcast = (rx_tei == TEI_BROADCAST);

  // SAPI widening per mode
  always_comb begin
    case (sapi_mode)
      SMODE_EXACT: sapi_ok = sapi_eq && cr_same;
      SMODE_OR_ZERO: sapi_ok = (sapi_eq || sapi_zero) && cr_same;
      SMODE_OR_ALL: sapi_ok = (sapi_eq || sapi_all) && cr_same;
      SMODE_ANY: sapi_ok = 1'b1;
      default: sapi_ok = 1'b0;
    endcase
  end

  // TEI widening per mode
  always_comb begin
    case (tei_mode)
      TMODE_UNDEF: tei_ok = 1'b0;
      TMODE_EXACT: tei_ok = tei_eq;
      TMODE_OR_BCAST: tei_ok = tei_eq || tei_bcast;
      TMODE_ANY: tei_ok = 1'b1;
      default: tei_ok = 1'b0;
    endcase
  end

  // Identifier hit needs both halves
  assign hit = sapi_ok && tei_ok;

endmodule // hdlcam_dlci_cmp

// File: sim/hdlcam_regs_test.sv
`timescale 1ns/10ps
module hdlcam_regs_test;
  import hdlcam_pkg::*;

  // Compare two values, count and report
  `define CHK(got, exp) begin \
    n_tests++; \
    if ((got) !== (exp)) begin \
      err_total++; \
      $display("ERROR t=%0t got=%h exp=%h", $time, (got), (exp)); \
    end \
  end

  // One recognition case: identifier, settings, received octets, result
  typedef struct {
    logic [1:0] d;
    logic [7:0] sp;
    logic [7:0] tp;
    logic [1:0] sm;
    logic [1:0] tm;
    logic cre;
    logic [7:0] rs;
    logic [7:0] rt;
    logic hit;
  } hdlcam_row_type;

  hdlcam_row_type rows [14] = '{
    '{2'h2, 8'h0C, 8'h03, 2'h0, 2'h1, 1'h0, 8'h0C, 8'h03, 1'h1},
    '{2'h2, 8'h0C, 8'h03, 2'h0, 2'h1, 1'h0, 8'h00, 8'h03, 1'h0},
    '{2'h3, 8'h0C, 8'h03, 2'h1, 2'h1, 1'h0, 8'h00, 8'h03, 1'h1},
    '{2'h3, 8'h0C, 8'h03, 2'h1, 2'h1, 1'h0, 8'hFC, 8'h03, 1'h0},
    '{2'h1, 8'h0C, 8'h03, 2'h2, 2'h1, 1'h0, 8'hFC, 8'h03, 1'h1},
    '{2'h1, 8'h0C, 8'h03, 2'h2, 2'h1, 1'h0, 8'h00, 8'h03, 1'h0},
    '{2'h2, 8'h0C, 8'h03, 2'h3, 2'h1, 1'h0, 8'h54, 8'h03, 1'h1},
    '{2'h3, 8'h0C, 8'h03, 2'h0, 2'h0, 1'h0, 8'h0C, 8'h03, 1'h0},
    '{2'h1, 8'h0C, 8'h03, 2'h0, 2'h1, 1'h0, 8'h0C, 8'h05, 1'h0},
    '{2'h2, 8'h0C, 8'h03, 2'h0, 2'h2, 1'h0, 8'h0C, 8'hFF, 1'h1},
    '{2'h3, 8'h0C, 8'h03, 2'h0, 2'h3, 1'h0, 8'h0C, 8'h55, 1'h1},
    '{2'h1, 8'h0E, 8'h03, 2'h0, 2'h1, 1'h1, 8'h0C, 8'h03, 1'h0},
    '{2'h1, 8'h0E, 8'h03, 2'h0, 2'h1, 1'h0, 8'h0C, 8'h03, 1'h1},
    '{2'h2, 8'h0C, 8'h02, 2'h0, 2'h1, 1'h0, 8'h0C, 8'h03, 1'h0}
  };

  logic aclk;
  logic aresetn;
  logic [ADDR_W-1:0] awaddr;
  logic awvalid;
  logic awready;
  logic [DATA_W-1:0] wdata;
  logic [3:0] wstrb;
  logic wvalid;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready;
  logic [ADDR_W-1:0] araddr;
  logic arvalid;
  logic arready;
  logic [DATA_W-1:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready;
  logic rx_frame_start;
  logic rx_octet_valid;
  logic [7:0] rx_octet;
  logic addr_checked;
  logic addr_match;
  logic [N_DLCI-1:0] addr_hit_dlci;
  int err_total = 0;
  int n_tests = 0;
  int cycles = 0;

  hdlcam_regs dut (
    .aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .rx_frame_start(rx_frame_start), .rx_octet_valid(rx_octet_valid),
    .rx_octet(rx_octet), .addr_checked(addr_checked),
    .addr_match(addr_match), .addr_hit_dlci(addr_hit_dlci)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard
  always #25 aclk = ~aclk;

  always @(posedge aclk) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      results();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic results();
    if (err_total == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Byte address of a register index
  function automatic logic [7:0] ba(input logic [5:0] i);
    return {i, 2'h0};
  endfunction

  // Bus write, address and data offered together
  task automatic axw(input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s, input logic [1:0] er);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'h0;
    w_ok = 1'h0;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && awready === 1'h1) begin
        awvalid <= 1'h0;
        aw_ok = 1'h1;
      end
      if (!w_ok && wready === 1'h1) begin
        wvalid <= 1'h0;
        w_ok = 1'h1;
      end
    end
    while (bvalid !== 1'h1) @(posedge aclk);
    `CHK(bresp, er)
  endtask

  // Bus read with expected word and response
  task automatic axr(input logic [7:0] a, input logic [31:0] ed,
                     input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do @(posedge aclk); while (arready !== 1'h1);
    arvalid <= 1'h0;
    while (rvalid !== 1'h1) @(posedge aclk);
    `CHK(rdata, ed)
    `CHK(rresp, er)
  endtask

  // Program one identifier, all others left undefined
  task automatic cfg(input hdlcam_row_type r);
    axw(ba(IDX_SAPI_PAT0 + 6'(2 * r.d)), {24'h0, r.sp}, 4'hF, RESP_OKAY);
    axw(ba(IDX_TEI_PAT0 + 6'(2 * r.d)), {24'h0, r.tp}, 4'hF, RESP_OKAY);
    axw(ba(IDX_SAPI_WIDEN), 32'(r.sm) << (2 * r.d), 4'hF, RESP_OKAY);
    axw(ba(IDX_TEI_WIDEN), 32'(r.tm) << (2 * r.d), 4'hF, RESP_OKAY);
    axw(ba(IDX_CR_ENABLE), 32'(r.cre) << r.d, 4'hF, RESP_OKAY);
  endtask

  // Send a frame start and two address octets, wait for the verdict
  task automatic frame(input logic [7:0] s, input logic [7:0] t);
    rx_frame_start <= 1'h1;
    @(posedge aclk);
    rx_frame_start <= 1'h0;
    rx_octet_valid <= 1'h1;
    rx_octet <= s;
    @(posedge aclk);
    rx_octet <= t;
    @(posedge aclk);
    rx_octet_valid <= 1'h0;
    rx_octet <= ~t;
    repeat (8) begin
      @(posedge aclk);
      if (addr_checked === 1'h1) break;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    aclk = 1'h0;
    aresetn = 1'h0;
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
    {rx_frame_start, rx_octet_valid, rx_octet} = '0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    // Table of recognition cases
    foreach (rows[i]) begin
      cfg(rows[i]);
      frame(rows[i].rs, rows[i].rt);
      `CHK(addr_checked, 1'h1)
      `CHK(addr_match, rows[i].hit)
      `CHK(addr_hit_dlci, 4'(rows[i].hit) << rows[i].d)
    end
    // Two identifiers hit at once; status mirrors it
    axw(ba(IDX_SAPI_PAT1), 32'h0C, 4'hF, RESP_OKAY);
    axw(ba(IDX_TEI_PAT1), 32'h03, 4'hF, RESP_OKAY);
    axw(ba(IDX_SAPI_PAT3), 32'h0C, 4'hF, RESP_OKAY);
    axw(ba(IDX_TEI_PAT3), 32'h03, 4'hF, RESP_OKAY);
    axw(ba(IDX_SAPI_WIDEN), 32'h00, 4'hF, RESP_OKAY);
    axw(ba(IDX_TEI_WIDEN), 32'h44, 4'hF, RESP_OKAY);
    axw(ba(IDX_CR_ENABLE), 32'h00, 4'hF, RESP_OKAY);
    frame(8'h0C, 8'h03);
    `CHK(addr_match, 1'h1)
    `CHK(addr_hit_dlci, 4'hA)
    axr(ba(IDX_STATUS), 32'h1A, RESP_OKAY);
    // Status is read-only: a write is accepted and changes nothing
    axw(ba(IDX_STATUS), 32'hFF, 4'hF, RESP_OKAY);
    axr(ba(IDX_STATUS), 32'h1A, RESP_OKAY);
    // Readback of registers 0x25 to 0x2A, upper lanes discarded
    for (int k = 'h25; k <= 'h2A; k++) begin
      axw(ba(6'(k)), {24'hABCDEF, 8'(k) ^ 8'h5A}, 4'hF, RESP_OKAY);
    end
    for (int k = 'h25; k <= 'h2A; k++) begin
      axr(ba(6'(k)), {24'h0, 8'(k) ^ 8'h5A}, RESP_OKAY);
    end
    // Lane 0 disabled stores nothing
    axw(ba(IDX_TEI_PAT1), 32'h11, 4'hE, RESP_OKAY);
    axr(ba(IDX_TEI_PAT1), 32'h7F, RESP_OKAY);
    // Unmapped address refused
    axw(8'h04, 32'h77, 4'hF, RESP_SLVERR);
    axr(8'h04, 32'h0, RESP_SLVERR);
    // Reset in mid-run clears handshakes and registers
    aresetn <= 1'h0;
    repeat (6) @(posedge aclk);
    `CHK(awready, 1'h0)
    `CHK(arready, 1'h0)
    `CHK(bvalid, 1'h0)
    `CHK(addr_hit_dlci, 4'h0)
    aresetn <= 1'h1;
    @(posedge aclk);
    for (int k = 'h25; k <= 'h2A; k++) begin
      axr(ba(6'(k)), 32'h0, RESP_OKAY);
    end
    frame(8'h0C, 8'h03);
    `CHK(addr_checked, 1'h1)
    `CHK(addr_match, 1'h0)
    results();
  end

endmodule // hdlcam_regs_test
